// ### dbp_defs.svh
// Constants for the dual bus parallel output port
`ifndef DBP_DEFS_SVH
`define DBP_DEFS_SVH

// Data widths
`define DBP_WORD_W        16
`define DBP_BYTE_W        8
`define DBP_SRC_SEL_W     2
`define DBP_ITEM_SEL_W    3

// Bus A direct source codes
`define DBP_A_SRC_INPHASE 2'h0
`define DBP_A_SRC_MAG     2'h1
`define DBP_A_SRC_FREQ    2'h2

// Bus B direct source codes
`define DBP_B_SRC_QUAD    2'h0
`define DBP_B_SRC_PHASE   2'h1
`define DBP_B_SRC_MAG     2'h2

// Buffered item select codes
`define DBP_ITEM_INPHASE  3'h0
`define DBP_ITEM_QUAD     3'h1
`define DBP_ITEM_MAG      3'h2
`define DBP_ITEM_PHASE    3'h3
`define DBP_ITEM_FREQ     3'h4

// Buffer sizing
`define DBP_FIFO_DEPTH    32
`define DBP_MAX_SETS      4'h7
`define DBP_SETS_W        4

// Buffer ready pulse length in clock cycles
`define DBP_IRQ_CYCLES    4'h8
`define DBP_IRQ_CNT_W     4

// Reset values
`define DBP_WORD_RST      16'h0000
`define DBP_SETS_RST      4'h0
`define DBP_IRQ_CNT_RST   4'h0

`endif

// ### dbp_pkg.sv
// Types shared by the dual bus parallel output port
`include "dbp_defs.svh"
package dbp_pkg;

  // One processed result: the five items of a data set
  typedef struct packed {
    logic [`DBP_WORD_W-1:0] inphase;
    logic [`DBP_WORD_W-1:0] quad;
    logic [`DBP_WORD_W-1:0] mag;
    logic [`DBP_WORD_W-1:0] phase;
    logic [`DBP_WORD_W-1:0] freq;
  } dbp_set_t;

  // Buffered set presenter states, one-hot
  typedef enum logic [1:0] {
    DBP_ST_EMPTY = 2'b01,
    DBP_ST_READY = 2'b10
  } dbp_state_t;

endpackage

// ### dbp_fifo.sv
// Parameterised FIFO with a registered read data stage
`timescale 1ns/1ps
`include "dbp_defs.svh"
module dbp_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // Storage array
  logic [AW-1:0]    wr_ptr_reg;      // Next write slot
  logic [AW-1:0]    rd_ptr_reg;      // Next read slot
  logic [AW:0]      count_reg;       // Words held in the array
  logic             out_valid_reg;   // Output register holds a word
  logic [WIDTH-1:0] out_data_reg;    // Registered read data
  logic             push;
  logic             pull;

  // Full and empty come straight from the array count
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  // Refill the output register whenever it is free or being taken
  assign pull      = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  // Array write; no reset needed on storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pull) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pull);
    end
  end

  // Output register; read data come from a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (pull) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

endmodule

// ### dbp_top.sv
// Dual bus parallel output port: direct port and buffered set port
`timescale 1ns/1ps
`include "dbp_defs.svh"
// Functional notes
// - Data, strobe and interrupt timed on core clock rising edge; byte drives combinational
// - Direct and buffered modes; direct source selectable
// - Upper bus bytes carry direct value upper byte
// - Direct bus updates on new result, strobe marks
// - Bus A I/mag/freq, bus B Q/phase/mag
// - Two's complement; magnitude unsigned, MSB zero
// - Buffer holds sets of five items, select picks
// - At most seven sets stored at once
// - Lower bytes form buffered word alongside direct data
// - Buffered values share direct port formats
// - Bus B low byte may carry direct data
// - Strobe active low, exactly one cycle, first
// - Buffer ready interrupt low for eight cycles
// - Byte drive off while its enable is high
module dbp_top (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         result_valid,
  output logic                              result_ready,
  input  wire dbp_pkg::dbp_set_t            result_set,
  input  wire logic [`DBP_SRC_SEL_W-1:0]    bus_a_src_sel,
  input  wire logic [`DBP_SRC_SEL_W-1:0]    bus_b_src_sel,
  input  wire logic                         buffer_enable,
  input  wire logic                         bus_b_low_direct,
  input  wire logic [`DBP_ITEM_SEL_W-1:0]   item_sel,
  input  wire logic                         buffer_next,
  input  wire logic                         bus_a_high_byte_oe_n,
  input  wire logic                         bus_a_low_byte_oe_n,
  input  wire logic                         bus_b_high_byte_oe_n,
  input  wire logic                         bus_b_low_byte_oe_n,
  output logic [`DBP_WORD_W-1:0]            output_bus_a,
  output logic [`DBP_WORD_W-1:0]            output_bus_b,
  output logic                              bus_a_high_drive_n,
  output logic                              bus_a_low_drive_n,
  output logic                              bus_b_high_drive_n,
  output logic                              bus_b_low_drive_n,
  output logic                              new_data_strobe_n,
  output logic                              buffer_ready_irq_n
);

  localparam int SET_W = $bits(dbp_pkg::dbp_set_t);

  // Direct port state
  logic [`DBP_WORD_W-1:0]     direct_a_reg;    // Bus A direct value
  logic [`DBP_WORD_W-1:0]     direct_b_reg;    // Bus B direct value
  logic                       strobe_n_reg;    // New data strobe
  logic                       accept;          // Result taken this cycle

  // Pin input synchronisers, three stages each
  logic [`DBP_ITEM_SEL_W-1:0] sel_s1_reg;
  logic [`DBP_ITEM_SEL_W-1:0] sel_s2_reg;
  logic [`DBP_ITEM_SEL_W-1:0] sel_s3_reg;
  logic [`DBP_ITEM_SEL_W-1:0] sel_reg;         // Settled select code
  logic [2:0]                 next_sync_reg;   // Advance pin stages
  logic                       next_level_reg;  // Settled advance level
  logic                       advance;         // Rising advance, one cycle

  // Buffered path
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;
  logic [SET_W-1:0]           fifo_out_data;
  logic                       buf_push;
  logic [`DBP_SETS_W-1:0]     sets_reg;        // Sets held, incl. current
  dbp_pkg::dbp_set_t          cur_set_reg;     // Set shown to the reader
  dbp_pkg::dbp_state_t        state_reg;
  dbp_pkg::dbp_state_t        state_next;
  logic [`DBP_WORD_W-1:0]     buf_word_reg;    // Selected buffered item
  logic [`DBP_IRQ_CNT_W-1:0]  irq_cnt_reg;     // Interrupt cycles left
  logic                       set_loaded;
  logic                       set_released;

  // Buffer may hold seven sets; a full buffer stalls the source
  assign buf_push     = buffer_enable && result_valid &&
                        (sets_reg != `DBP_MAX_SETS) && fifo_in_ready;
  assign result_ready = !buffer_enable ||
                        ((sets_reg != `DBP_MAX_SETS) && fifo_in_ready);
  assign accept       = result_valid && result_ready;

  // Direct bus values; magnitude MSB forced low, others passed as is
  always_ff @(posedge core_clk) begin
    if (rst) begin
      direct_a_reg <= `DBP_WORD_RST;
      direct_b_reg <= `DBP_WORD_RST;
    end else if (accept) begin
      case (bus_a_src_sel)
        `DBP_A_SRC_MAG: begin
          direct_a_reg <= {1'b0, result_set.mag[`DBP_WORD_W-2:0]};
        end
        `DBP_A_SRC_FREQ: begin
          direct_a_reg <= result_set.freq;
        end
        default: begin
          direct_a_reg <= result_set.inphase;
        end
      endcase
      case (bus_b_src_sel)
        `DBP_B_SRC_PHASE: begin
          direct_b_reg <= result_set.phase;
        end
        `DBP_B_SRC_MAG: begin
          direct_b_reg <= {1'b0, result_set.mag[`DBP_WORD_W-2:0]};
        end
        default: begin
          direct_b_reg <= result_set.quad;
        end
      endcase
    end
  end

  // Strobe low only in the first cycle new data is on the buses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_n_reg <= 1'b1;
    end else begin
      strobe_n_reg <= !accept;
    end
  end

  // Select pins: a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_s1_reg <= `DBP_ITEM_INPHASE;
      sel_s2_reg <= `DBP_ITEM_INPHASE;
      sel_s3_reg <= `DBP_ITEM_INPHASE;
      sel_reg    <= `DBP_ITEM_INPHASE;
    end else begin
      sel_s1_reg <= item_sel;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      if (sel_s2_reg == sel_s3_reg) begin
        sel_reg <= sel_s3_reg;
      end
    end
  end

  // Advance pin; the edge detect needs stages two and three agreeing high while the settled level is still low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      next_sync_reg  <= 3'h0;
      next_level_reg <= 1'b0;
    end else begin
      next_sync_reg <= {next_sync_reg[1:0], buffer_next};
      if (next_sync_reg[1] == next_sync_reg[2]) begin
        next_level_reg <= next_sync_reg[2];
      end
    end
  end

  assign advance = (next_sync_reg[1] == next_sync_reg[2]) &&
                   next_sync_reg[2] && !next_level_reg;

  // Set storage; first in, first out
  dbp_fifo #(
    .WIDTH (SET_W),
    .DEPTH (`DBP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_ready  (fifo_in_ready),
    .in_data   (result_set),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Presenter takes the oldest set when nothing is shown
  assign set_loaded     = (state_reg == dbp_pkg::DBP_ST_EMPTY) &&
                          fifo_out_valid;
  assign set_released   = (state_reg == dbp_pkg::DBP_ST_READY) && advance;
  assign fifo_out_ready = (state_reg == dbp_pkg::DBP_ST_EMPTY);

  // Presenter next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dbp_pkg::DBP_ST_EMPTY: begin
        if (fifo_out_valid) begin
          state_next = dbp_pkg::DBP_ST_READY;
        end
      end
      dbp_pkg::DBP_ST_READY: begin
        if (advance) begin
          state_next = dbp_pkg::DBP_ST_EMPTY;
        end
      end
      default: begin
        state_next = dbp_pkg::DBP_ST_EMPTY;
      end
    endcase
  end

  // Presenter state and current set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg   <= dbp_pkg::DBP_ST_EMPTY;
      cur_set_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (set_loaded) begin
        cur_set_reg <= dbp_pkg::dbp_set_t'(fifo_out_data);
      end
    end
  end

  // Occupancy counts a set from push until the reader releases it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sets_reg <= `DBP_SETS_RST;
    end else begin
      sets_reg <= sets_reg + `DBP_SETS_W'(buf_push)
                           - `DBP_SETS_W'(set_released);
    end
  end

  // Selected item; codes above frequency read as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_word_reg <= `DBP_WORD_RST;
    end else begin
      case (sel_reg)
        `DBP_ITEM_INPHASE: buf_word_reg <= cur_set_reg.inphase;
        `DBP_ITEM_QUAD:    buf_word_reg <= cur_set_reg.quad;
        `DBP_ITEM_MAG: begin
          buf_word_reg <= {1'b0, cur_set_reg.mag[`DBP_WORD_W-2:0]};
        end
        `DBP_ITEM_PHASE:   buf_word_reg <= cur_set_reg.phase;
        `DBP_ITEM_FREQ:    buf_word_reg <= cur_set_reg.freq;
        default:           buf_word_reg <= `DBP_WORD_RST;
      endcase
    end
  end

  // Interrupt held low for eight cycles when a set becomes readable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_cnt_reg <= `DBP_IRQ_CNT_RST;
    end else if (set_loaded) begin
      irq_cnt_reg <= `DBP_IRQ_CYCLES;
    end else if (irq_cnt_reg != `DBP_IRQ_CNT_RST) begin
      irq_cnt_reg <= irq_cnt_reg - 1'b1;
    end
  end

  assign buffer_ready_irq_n = (irq_cnt_reg == `DBP_IRQ_CNT_RST);
  assign new_data_strobe_n  = strobe_n_reg;

  // Upper bytes always direct; lower bytes buffered unless B overridden
  assign output_bus_a = {direct_a_reg[`DBP_WORD_W-1:`DBP_BYTE_W],
                         buf_word_reg[`DBP_WORD_W-1:`DBP_BYTE_W]};
  assign output_bus_b = {direct_b_reg[`DBP_WORD_W-1:`DBP_BYTE_W],
                         bus_b_low_direct ?
                         direct_b_reg[`DBP_BYTE_W-1:0] :
                         buf_word_reg[`DBP_BYTE_W-1:0]};

  // Byte drivers follow the enables at once; bus turnaround is external
  assign bus_a_high_drive_n = bus_a_high_byte_oe_n;
  assign bus_a_low_drive_n  = bus_a_low_byte_oe_n;
  assign bus_b_high_drive_n = bus_b_high_byte_oe_n;
  assign bus_b_low_drive_n  = bus_b_low_byte_oe_n;

endmodule

// ### dbp_top_asserts.sv
// Pin-level checks for the dual bus output port
`timescale 1ns/1ps
module dbp_top_asserts (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              result_valid,
  input wire logic              result_ready,
  input wire dbp_pkg::dbp_set_t result_set,
  input wire logic [1:0]        bus_a_src_sel,
  input wire logic [1:0]        bus_b_src_sel,
  input wire logic              buffer_enable,
  input wire logic              bus_a_high_byte_oe_n,
  input wire logic              bus_a_low_byte_oe_n,
  input wire logic              bus_b_high_byte_oe_n,
  input wire logic              bus_b_low_byte_oe_n,
  input wire logic [15:0]       output_bus_a,
  input wire logic [15:0]       output_bus_b,
  input wire logic              bus_a_high_drive_n,
  input wire logic              bus_a_low_drive_n,
  input wire logic              bus_b_high_drive_n,
  input wire logic              bus_b_low_drive_n,
  input wire logic              new_data_strobe_n,
  input wire logic              buffer_ready_irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // One result taken on this edge
  wire logic acc = result_valid && result_ready;

  strobe_on_a: assert property (acc |=> !new_data_strobe_n)
    else $error("strobe missing after accept");
  strobe_cause_a: assert property (
    !new_data_strobe_n |-> $past(acc))
    else $error("strobe without accept");
  upper_freq_a: assert property ((acc && bus_a_src_sel == 2'h2) |=>
    output_bus_a[15:8] == $past(result_set.freq[15:8]))
    else $error("bus a upper byte wrong");
  upper_phase_a: assert property ((acc && bus_b_src_sel == 2'h1) |=>
    output_bus_b[15:8] == $past(result_set.phase[15:8]))
    else $error("bus b upper byte wrong");
  mag_sign_a: assert property ((acc && bus_b_src_sel == 2'h2) |=>
    !output_bus_b[15])
    else $error("magnitude msb set");
  upper_hold_a: assert property (
    !acc |=> $stable(output_bus_a[15:8]))
    else $error("bus a moved without result");
  irq_len_a: assert property ($fell(buffer_ready_irq_n) |->
    (!buffer_ready_irq_n) [*8] ##1 buffer_ready_irq_n)
    else $error("interrupt length wrong");
  byte_drive_a: assert property (
    {bus_a_high_drive_n, bus_a_low_drive_n, bus_b_high_drive_n,
    bus_b_low_drive_n} == {bus_a_high_byte_oe_n, bus_a_low_byte_oe_n,
    bus_b_high_byte_oe_n, bus_b_low_byte_oe_n})
    else $error("byte drive does not follow enable");
  ready_direct_a: assert property (!buffer_enable |-> result_ready)
    else $error("direct mode stalled");

  // Main scenarios reached
  cover property (acc);
  cover property ($fell(buffer_ready_irq_n));
  cover property (result_valid && !result_ready);
endmodule

bind dbp_top dbp_top_asserts dbp_top_asserts_i (.core_clk, .rst,
  .result_valid, .result_ready, .result_set, .bus_a_src_sel, .bus_b_src_sel,
  .buffer_enable, .bus_a_high_byte_oe_n, .bus_a_low_byte_oe_n,
  .bus_b_high_byte_oe_n, .bus_b_low_byte_oe_n, .output_bus_a, .output_bus_b,
  .bus_a_high_drive_n, .bus_a_low_drive_n, .bus_b_high_drive_n,
  .bus_b_low_drive_n, .new_data_strobe_n, .buffer_ready_irq_n);

// ### dbp_reader_model.sv
// Behavioural processor that selects and releases buffered items
`timescale 1ns/1ps
module dbp_reader_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] output_bus_a,
  input  wire logic [15:0] output_bus_b,
  input  wire logic        bus_a_low_drive_n,
  input  wire logic        bus_b_low_drive_n,
  output logic [2:0]       item_sel,
  output logic             buffer_next,
  output logic             bus_a_high_byte_oe_n,
  output logic             bus_a_low_byte_oe_n,
  output logic             bus_b_high_byte_oe_n,
  output logic             bus_b_low_byte_oe_n
);
  // Undriven low bytes read inverted, so a missing drive never reads as data
  wire logic [7:0] a_lo = bus_a_low_drive_n ? ~output_bus_a[7:0] :
                                              output_bus_a[7:0];
  wire logic [7:0] b_lo = bus_b_low_drive_n ? ~output_bus_b[7:0] :
                                              output_bus_b[7:0];

  // Upper bytes stay enabled so direct data is always visible
  initial begin
    item_sel = 3'h0;
    buffer_next = 1'h0;
    {bus_a_high_byte_oe_n, bus_b_high_byte_oe_n} = 2'h0;
    {bus_a_low_byte_oe_n, bus_b_low_byte_oe_n} = 2'h3;
  end

  // Select an item, enable the low bytes, wait for the select to settle
  task automatic read_word(input logic [2:0] code, output logic [15:0] w);
    @(posedge core_clk);
    #1;
    item_sel = code;
    {bus_a_low_byte_oe_n, bus_b_low_byte_oe_n} = 2'h0;
    repeat (8) @(posedge core_clk);
    #1;
    w = {a_lo, b_lo};
    {bus_a_low_byte_oe_n, bus_b_low_byte_oe_n} = 2'h3;
  endtask

  // Held long enough for the pin synchroniser to see the rise
  task automatic release_set();
    @(posedge core_clk);
    #1;
    buffer_next = 1'h1;
    repeat (6) @(posedge core_clk);
    #1;
    buffer_next = 1'h0;
    repeat (8) @(posedge core_clk);
    // Hand back off the edge so the caller's stimulus never races it
    #1;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the dual bus output port
`timescale 1ns/1ps
module tb_top;
  logic              core_clk, rst, result_valid, result_ready;
  logic              buffer_enable, bus_b_low_direct, buffer_next;
  logic              new_data_strobe_n, buffer_ready_irq_n, prev_irq;
  logic              bus_a_high_byte_oe_n, bus_a_low_byte_oe_n;
  logic              bus_b_high_byte_oe_n, bus_b_low_byte_oe_n;
  logic              bus_a_high_drive_n, bus_a_low_drive_n;
  logic              bus_b_high_drive_n, bus_b_low_drive_n;
  logic [1:0]        bus_a_src_sel, bus_b_src_sel;
  logic [2:0]        item_sel;
  logic [15:0]       output_bus_a, output_bus_b;
  dbp_pkg::dbp_set_t result_set;
  int                n_mismatch, comparisons, cyc, irq_falls;
  // Item code carried by each direct source code
  logic [2:0]        amap [4] = '{3'h0, 3'h2, 3'h4, 3'h0};
  logic [2:0]        bmap [4] = '{3'h1, 3'h3, 3'h2, 3'h1};

  dbp_top dbp_top_i (.core_clk, .rst, .result_valid, .result_ready,
    .result_set, .bus_a_src_sel, .bus_b_src_sel, .buffer_enable,
    .bus_b_low_direct, .item_sel, .buffer_next, .bus_a_high_byte_oe_n,
    .bus_a_low_byte_oe_n, .bus_b_high_byte_oe_n, .bus_b_low_byte_oe_n,
    .output_bus_a, .output_bus_b, .bus_a_high_drive_n, .bus_a_low_drive_n,
    .bus_b_high_drive_n, .bus_b_low_drive_n, .new_data_strobe_n,
    .buffer_ready_irq_n);
  dbp_reader_model dbp_reader_model_i (.core_clk, .output_bus_a,
    .output_bus_b, .bus_a_low_drive_n, .bus_b_low_drive_n, .item_sel,
    .buffer_next, .bus_a_high_byte_oe_n, .bus_a_low_byte_oe_n,
    .bus_b_high_byte_oe_n, .bus_b_low_byte_oe_n);

  // 40 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Interrupt falls counted; a hang is cut off well past the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (prev_irq && !buffer_ready_irq_n) irq_falls++;
    prev_irq = buffer_ready_irq_n;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Magnitude has a set sign bit to prove it is forced to zero
  function automatic dbp_pkg::dbp_set_t mk(input logic [7:0] k);
    mk = {8'h10, k, 8'h20, k, 8'h80, k, 8'h40, k, 8'hc0, k};
  endfunction

  function automatic logic [15:0] pick(input dbp_pkg::dbp_set_t s,
                                       input logic [2:0] c);
    case (c)
      3'h0: pick = s.inphase;
      3'h1: pick = s.quad;
      3'h2: pick = {1'h0, s.mag[14:0]};
      3'h3: pick = s.phase;
      3'h4: pick = s.freq;
      default: pick = 16'h0000;
    endcase
  endfunction

  // Offer a set; valid stays up for the caller to drop or reuse
  task automatic send(input dbp_pkg::dbp_set_t s, input int lim,
                      output bit ok);
    result_set = s;
    result_valid = 1'h1;
    ok = 1'h0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge core_clk);
      ok = result_ready;
      #1;
    end
  endtask

  task automatic t_direct();
    dbp_pkg::dbp_set_t s;
    logic [15:0] ea, eb;
    bit ok;
    chk({14'h0000, new_data_strobe_n, buffer_ready_irq_n}, 16'h0003,
        "idle");
    for (int c = 0; c < 4; c++) begin
      s = mk(8'(c));
      ea = pick(s, amap[c]);
      eb = pick(s, bmap[c]);
      bus_a_src_sel = 2'(c);
      bus_b_src_sel = 2'(c);
      send(s, 3, ok);
      result_valid = 1'h0;
      chk({15'h0000, new_data_strobe_n}, 16'h0000, "strobe");
      chk({output_bus_a[15:8], output_bus_b[15:8]}, {ea[15:8], eb[15:8]},
          "upper bytes");
      @(posedge core_clk);
      #1;
      chk({15'h0000, new_data_strobe_n}, 16'h0001, "strobe width");
      chk({8'h00, output_bus_b[7:0]}, {8'h00, eb[7:0]}, "b low");
    end
    send(mk(8'h40), 3, ok);
    send(mk(8'h41), 3, ok);
    result_valid = 1'h0;
    chk({15'h0000, new_data_strobe_n}, 16'h0000, "strobe b2b");
    chk({8'h00, output_bus_b[7:0]}, 16'h0041, "second result");
  endtask

  task automatic t_buffer();
    dbp_pkg::dbp_set_t sent[$];
    logic [15:0] w;
    bit ok;
    buffer_enable = 1'h1;
    bus_b_low_direct = 1'h0;
    bus_a_src_sel = 2'h2;
    irq_falls = 0;
    for (int k = 0; k < 8; k++) begin
      send(mk(8'(8'h20 + k)), 3, ok);
      if (ok) sent.push_back(mk(8'(8'h20 + k)));
    end
    result_valid = 1'h0;
    chk(16'(sent.size()), 16'h0007, "sets held");
    chk({8'h00, output_bus_a[15:8]}, 16'h00c0, "direct beside");
    for (int k = 0; k < 8; k++) begin
      for (int c = 0; c < 8; c++) begin
        dbp_reader_model_i.read_word(3'(c), w);
        chk(w, pick(sent[k], 3'(c)), "buffered item");
      end
      dbp_reader_model_i.release_set();
      if (k == 0) begin
        send(mk(8'h30), 3, ok);
        result_valid = 1'h0;
        sent.push_back(mk(8'h30));
        chk({15'h0000, ok}, 16'h0001, "room after release");
      end
    end
    chk(16'(irq_falls), 16'h0008, "ready pulses");
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst = 1'h1;
    prev_irq = 1'h1;
    result_valid = 1'h0;
    result_set = '0;
    bus_a_src_sel = 2'h0;
    bus_b_src_sel = 2'h0;
    buffer_enable = 1'h0;
    bus_b_low_direct = 1'h1;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'h0;
    t_direct();
    t_buffer();
    end_of_test();
  end
endmodule
